// ---- vitt_irq_ctrl.sv ----
// vectored interrupt controller with microsecond timer and axi4-lite registers
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
module vitt_irq_ctrl #(
    parameter int unsigned GPIO_PINS = 32,
    parameter int unsigned SINK_PINS = 4
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 usb_bus_reset_evt,
    input  wire logic [4:0]           ep_done_evt,
    input  wire logic                 ser_done_evt,
    input  wire logic [SINK_PINS-1:0] sink_pins,
    input  wire logic [GPIO_PINS-1:0] gpio_pins,
    output logic                      irq,
    output logic                      irq_valid,
    output logic [3:0]                irq_vector
);
    localparam int unsigned NP = GPIO_PINS / vitt_pkg::PORT_W; // ports

    // refuse sizes the register layout cannot hold, at elaboration
    if (GPIO_PINS == 0 || GPIO_PINS > 32 || GPIO_PINS % vitt_pkg::PORT_W != 0 ||
        SINK_PINS == 0 || SINK_PINS > 8) begin : g_size_chk
        $error("vitt_irq_ctrl: unsupported pin counts");
    end

    // ****************************************************************
    // state
    // ****************************************************************
    logic [10:0]          stat_q;    // sticky pending sources
    logic [10:0]          mask_q;    // per-source enable
    logic [11:0]          tmr_q;     // free-running timer
    logic [4:0]           div_q;     // tick divider
    logic                 tick;      // one-cycle microsecond tick
    logic [3:0]           hold_q;    // upper timer bits, latched
    logic [1:0]           tap_q;     // previous tap levels
    logic [SINK_PINS-1:0] smask_q;   // sink pin mask
    logic [SINK_PINS-1:0] spol_q;    // sink polarity, 1 = falling
    logic [GPIO_PINS-1:0] gmask_q;   // gpio pin mask
    logic [NP-1:0]        gpol_q;    // gpio polarity per port
    logic [SINK_PINS-1:0] s_m_q;     // sink sync stage 1
    logic [SINK_PINS-1:0] s_s_q;     // sink sync stage 2
    logic [SINK_PINS-1:0] s_p_q;     // sink previous level
    logic [GPIO_PINS-1:0] g_m_q;     // gpio sync stage 1
    logic [GPIO_PINS-1:0] g_s_q;     // gpio sync stage 2
    logic [GPIO_PINS-1:0] g_p_q;     // gpio previous level
    logic [2:0]           arm_q;     // edges ignored until sync filled
    logic [GPIO_PINS-1:0] gpol_x;    // port polarity spread to pins
    logic [SINK_PINS-1:0] sink_hit;  // qualifying sink edges
    logic [GPIO_PINS-1:0] gpio_hit;  // qualifying gpio edges
    logic [10:0]          evt;       // source events this cycle
    logic [10:0]          clr;       // w1c clear bits
    logic [3:0]           pick;      // lowest pending vector
    logic                 pend;      // any enabled source pending
    logic [7:0]           aw_q;      // held write address
    logic                 aw_h_q;    // write address held
    logic [31:0]          wd_q;      // held write data
    logic [3:0]           ws_q;      // held write strobes
    logic                 w_h_q;     // write data held
    logic                 wr_go;     // both halves present
    logic [31:0]          bm;        // byte mask from strobes
    logic                 rd_go;     // read address taken

    // ****************************************************************
    // microsecond tick and twelve-bit timer
    // ****************************************************************
    // divider turns aclk into a one-cycle tick every TICK_DIV cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 5'h0;
        end else if (div_q == 5'(vitt_pkg::TICK_DIV - 1)) begin
            div_q <= 5'h0;
        end else begin
            div_q <= div_q + 5'h1;
        end
    end
    assign tick = (div_q == 5'(vitt_pkg::TICK_DIV - 1));

    // no start or stop: the count wraps forever
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmr_q <= 12'h000;
        end else if (tick) begin
            tmr_q <= tmr_q + 12'h001;
        end
    end

    // tap history for rising-change detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_q <= 2'h0;
        end else begin
            tap_q <= {tmr_q[vitt_pkg::TAP_SLOW], tmr_q[vitt_pkg::TAP_FAST]};
        end
    end

    // ****************************************************************
    // pin synchronisers and edge detectors
    // ****************************************************************
    // stage 1 feeds stage 2 only; edges come from stages 2 and 3
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_m_q <= '0;
            s_s_q <= '0;
            s_p_q <= '0;
            g_m_q <= '0;
            g_s_q <= '0;
            g_p_q <= '0;
            arm_q <= 3'h0;
        end else begin
            s_m_q <= sink_pins;
            s_s_q <= s_m_q;
            s_p_q <= s_s_q;
            g_m_q <= gpio_pins;
            g_s_q <= g_m_q;
            g_p_q <= g_s_q;
            arm_q <= {arm_q[1:0], 1'b1};
        end
    end

    // port polarity applies to all eight pins of a port
    for (genvar p = 0; p < NP; p++) begin : g_pol
        assign gpol_x[p*8 +: 8] = {8{gpol_q[p]}};
    end

    // polarity 0 picks 0-to-1, polarity 1 picks 1-to-0
    // the arm delay hides the false edge from reset-zeroed history
    assign sink_hit = arm_q[2] ? (smask_q & (s_s_q ^ s_p_q) & ~(s_s_q ^ ~spol_q))
                               : '0;
    assign gpio_hit = arm_q[2] ? (gmask_q & (g_s_q ^ g_p_q) & ~(g_s_q ^ ~gpol_x))
                               : '0;

    // ****************************************************************
    // source events, status, vector
    // ****************************************************************
    always_comb begin
        evt                          = 11'h000;
        evt[vitt_pkg::SRC_BUSRST]    = usb_bus_reset_evt;
        evt[vitt_pkg::SRC_T128]      = tmr_q[vitt_pkg::TAP_FAST] & ~tap_q[0];
        evt[vitt_pkg::SRC_T1024]     = tmr_q[vitt_pkg::TAP_SLOW] & ~tap_q[1];
        evt[vitt_pkg::SRC_EP0 +: 5]  = ep_done_evt;
        evt[vitt_pkg::SRC_SINK]      = |sink_hit;
        evt[vitt_pkg::SRC_GPIO]      = |gpio_hit;
        evt[vitt_pkg::SRC_SER]       = ser_done_evt;
    end

    assign clr = (wr_go && aw_q == vitt_pkg::OFS_STAT) ? (wd_q[10:0] & bm[10:0]) : 11'h000;

    // sticky pending bits; a new event beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= vitt_pkg::RST_ZERO[10:0];
        end else begin
            stat_q <= (stat_q & ~clr) | evt;
        end
    end

    // lowest-numbered enabled pending source owns the vector
    always_comb begin
        pick = 4'h0;
        pend = 1'b0;
        for (int i = vitt_pkg::N_SRC - 1; i >= 0; i--) begin
            if (stat_q[i] && mask_q[i]) begin
                pick = 4'(i);
                pend = 1'b1;
            end
        end
    end

    // vector registered for the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_vector <= 4'h0;
            irq_valid  <= 1'b0;
        end else begin
            irq_vector <= pick;
            irq_valid  <= pend;
        end
    end
    assign irq = |(stat_q & mask_q);

    // ****************************************************************
    // axi4-lite write side
    // ****************************************************************
    assign s_axi_awready = !aw_h_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_h_q && !s_axi_bvalid;
    assign wr_go         = aw_h_q && w_h_q;
    assign bm = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

    // address and data accepted in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 8'h00;
            aw_h_q <= 1'b0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            w_h_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= vitt_pkg::RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= s_axi_awaddr;
                aw_h_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_h_q <= 1'b1;
            end
            if (wr_go) begin
                aw_h_q <= 1'b0;
                w_h_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_q == vitt_pkg::OFS_STAT || aw_q == vitt_pkg::OFS_MASK ||
                    aw_q == vitt_pkg::OFS_SMASK || aw_q == vitt_pkg::OFS_SPOL ||
                    aw_q == vitt_pkg::OFS_GMASK || aw_q == vitt_pkg::OFS_GPOL) begin
                    s_axi_bresp <= vitt_pkg::RESP_OK;
                end else begin
                    s_axi_bresp <= vitt_pkg::RESP_ERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable configuration, honouring byte strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q  <= vitt_pkg::RST_ZERO[10:0];
            smask_q <= '0;
            spol_q  <= '0;
            gmask_q <= '0;
            gpol_q  <= '0;
        end else if (wr_go) begin
            if (aw_q == vitt_pkg::OFS_MASK) begin
                mask_q <= (mask_q & ~bm[10:0]) | (wd_q[10:0] & bm[10:0]);
            end else if (aw_q == vitt_pkg::OFS_SMASK) begin
                smask_q <= (smask_q & ~bm[SINK_PINS-1:0]) | (wd_q[SINK_PINS-1:0] & bm[SINK_PINS-1:0]);
            end else if (aw_q == vitt_pkg::OFS_SPOL) begin
                spol_q <= (spol_q & ~bm[SINK_PINS-1:0]) | (wd_q[SINK_PINS-1:0] & bm[SINK_PINS-1:0]);
            end else if (aw_q == vitt_pkg::OFS_GMASK) begin
                gmask_q <= (gmask_q & ~bm[GPIO_PINS-1:0]) | (wd_q[GPIO_PINS-1:0] & bm[GPIO_PINS-1:0]);
            end else if (aw_q == vitt_pkg::OFS_GPOL) begin
                gpol_q <= (gpol_q & ~bm[NP-1:0]) | (wd_q[NP-1:0] & bm[NP-1:0]);
            end
        end
    end

    // ****************************************************************
    // axi4-lite read side
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    // read data captured at address accept; answer next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= vitt_pkg::RST_ZERO;
            s_axi_rresp  <= vitt_pkg::RESP_OK;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= vitt_pkg::RESP_OK;
            s_axi_rdata  <= vitt_pkg::RST_ZERO;
            if (s_axi_araddr == vitt_pkg::OFS_STAT) begin
                s_axi_rdata[10:0] <= stat_q;
            end else if (s_axi_araddr == vitt_pkg::OFS_MASK) begin
                s_axi_rdata[10:0] <= mask_q;
            end else if (s_axi_araddr == vitt_pkg::OFS_VEC) begin
                s_axi_rdata[4:0] <= {pend, pick};
            end else if (s_axi_araddr == vitt_pkg::OFS_TLO) begin
                s_axi_rdata[7:0] <= tmr_q[7:0];
            end else if (s_axi_araddr == vitt_pkg::OFS_THI) begin
                s_axi_rdata[3:0] <= hold_q;
            end else if (s_axi_araddr == vitt_pkg::OFS_SMASK) begin
                s_axi_rdata[SINK_PINS-1:0] <= smask_q;
            end else if (s_axi_araddr == vitt_pkg::OFS_SPOL) begin
                s_axi_rdata[SINK_PINS-1:0] <= spol_q;
            end else if (s_axi_araddr == vitt_pkg::OFS_GMASK) begin
                s_axi_rdata[GPIO_PINS-1:0] <= gmask_q;
            end else if (s_axi_araddr == vitt_pkg::OFS_GPOL) begin
                s_axi_rdata[NP-1:0] <= gpol_q;
            end else begin
                s_axi_rresp <= vitt_pkg::RESP_ERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // upper bits frozen by the low read so a carry cannot tear them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= 4'h0;
        end else if (rd_go && s_axi_araddr == vitt_pkg::OFS_TLO) begin
            hold_q <= tmr_q[11:8];
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_timer_step: assert property (tick |=> tmr_q == $past(tmr_q) + 12'h001)
        else $error("timer did not advance on tick");
    a_tick_period: assert property (tick |-> ##20 tick)
        else $error("tick period is not twenty cycles");
    a_tap_fast: assert property ($rose(tmr_q[6]) |=> stat_q[1])
        else $error("bit 6 rise did not set its source");
    a_tap_slow: assert property ($rose(tmr_q[9]) |=> stat_q[2])
        else $error("bit 9 rise did not set its source");
    a_hold_latch: assert property (rd_go && s_axi_araddr == vitt_pkg::OFS_TLO |=>
                                   hold_q == $past(tmr_q[11:8]))
        else $error("low read did not latch upper bits");
    a_hi_held: assert property (rd_go && s_axi_araddr == vitt_pkg::OFS_THI |=>
                                s_axi_rdata[3:0] == hold_q)
        else $error("upper read did not return held bits");
    a_ep_set: assert property (ep_done_evt != 5'h0 |=> (stat_q[7:3] & $past(ep_done_evt)) == $past(ep_done_evt))
        else $error("endpoint event lost");
    a_sink_cause: assert property ($rose(stat_q[8]) |-> $past(|sink_hit))
        else $error("sink source set without a masked edge");
    a_gpio_cause: assert property ($rose(stat_q[9]) |-> $past(|gpio_hit))
        else $error("pin source set without a masked edge");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");

    c_gpio_irq: cover property (|gpio_hit ##1 irq);
    c_slow_tap: cover property ($rose(stat_q[2]));
    c_hold_read: cover property (rd_go && s_axi_araddr == vitt_pkg::OFS_TLO ##[1:40]
                                 rd_go && s_axi_araddr == vitt_pkg::OFS_THI);
endmodule : vitt_irq_ctrl

// ---- vitt_pkg.sv ----
// constants shared by the vectored interrupt controller and its tick timer
// Overview of operation
// - eleven sources, each maskable, each own vector
// - bus reset, taps, endpoints, sink, pins, serial
// - twelve-bit timer counts every microsecond, free
// - timer taps at bit 6 and bit 9
// - tap request only on rising change, enabled
// - low timer read latches upper four bits
// - upper timer read returns held bits
// - endpoint raises request on buffer or sent
// - sink port has per-pin mask
// - general-purpose ports have per-pin mask
// - sink edge polarity chosen per pin
// - general-purpose edge polarity chosen per port
// - polarity selects rising or falling change
// - all general-purpose pin events merge into one vector
package vitt_pkg;
    // ****************************************************************
    // source numbering, which is also the vector number
    // ****************************************************************
    localparam int unsigned N_SRC      = 11;   // source count
    localparam int unsigned N_EP       = 5;    // usb endpoints
    localparam int unsigned SRC_BUSRST = 0;    // usb bus reset
    localparam int unsigned SRC_T128   = 1;    // timer bit 6 tap
    localparam int unsigned SRC_T1024  = 2;    // timer bit 9 tap
    localparam int unsigned SRC_EP0    = 3;    // first endpoint
    localparam int unsigned SRC_SINK   = 8;    // current-sink port
    localparam int unsigned SRC_GPIO   = 9;    // shared pin vector
    localparam int unsigned SRC_SER    = 10;   // two-wire master
    // ****************************************************************
    // timer
    // ****************************************************************
    localparam int unsigned TMR_W        = 12;  // timer width
    localparam int unsigned TAP_FAST     = 6;   // 128 us tap
    localparam int unsigned TAP_SLOW     = 9;   // 1.024 ms tap
    localparam int unsigned CLK_NS       = 50;  // aclk period in ns
    localparam int unsigned TICK_NS      = 1000; // tick period in ns
    localparam int unsigned TICK_DIV     = TICK_NS / CLK_NS; // cycles
    localparam int unsigned PORT_W       = 8;   // pins per port
    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_STAT   = 8'h00; // sticky, w1c
    localparam logic [7:0] OFS_MASK   = 8'h04; // source enables
    localparam logic [7:0] OFS_VEC    = 8'h08; // pending vector
    localparam logic [7:0] OFS_TLO    = 8'h0C; // timer low bits
    localparam logic [7:0] OFS_THI    = 8'h10; // held upper bits
    localparam logic [7:0] OFS_SMASK  = 8'h14; // sink pin mask
    localparam logic [7:0] OFS_SPOL   = 8'h18; // sink pin polarity
    localparam logic [7:0] OFS_GMASK  = 8'h1C; // gpio pin mask
    localparam logic [7:0] OFS_GPOL   = 8'h20; // gpio port polarity
    // ****************************************************************
    // reset values and bus answers
    // ****************************************************************
    localparam logic [31:0] RST_ZERO  = 32'h0000_0000; // all resets
    localparam logic [1:0]  RESP_OK   = 2'h0;   // okay
    localparam logic [1:0]  RESP_ERR  = 2'h2;   // slverr, unmapped
endpackage : vitt_pkg

// ---- vitt_core_model.sv ----
// processor core stand-in that fetches the interrupt vector once at each rising edge of irq_valid
module vitt_core_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       irq_valid,
    input  wire logic [3:0] irq_vector,
    output logic      [3:0] taken_vec
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_q; // request seen one cycle ago
    // ****************************************************************
    // vector fetch
    // ****************************************************************
    // a core fetches once per fresh request, so a held request counts once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q    <= 1'b0;
            taken_vec <= 4'h0;
        end else begin
            prev_q <= irq_valid;
            if (irq_valid && !prev_q) begin
                taken_vec <= irq_vector;
            end
        end
    end
endmodule : vitt_core_model

// ---- vectored_irq_with_tick_timer_tb.sv ----
// self-checking bench for the vectored interrupt controller and tick timer
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module vectored_irq_with_tick_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;       // clock, sync reset
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, gpio_pins = 32'h0, rdat, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, sink_pins = 4'h0, irq_vector, taken_vec;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        usb_bus_reset_evt = 1'b0, ser_done_evt = 1'b0;
    logic [4:0]  ep_done_evt = 5'h00;                // endpoint pulses
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        irq, irq_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;   // last bus answer
    logic [15:0] lfsr_q = 16'h0D71;                 // seed 3441
    int          n_mismatch = 0, checks = 0, cyc = 0;
    int          i, k, s, t1, t2, c1, c2, d, e;
    int          srcs [7] = '{0, 3, 4, 5, 6, 7, 10}; // pulse-driven sources
    vitt_irq_ctrl vitt_irq_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .usb_bus_reset_evt, .ep_done_evt, .ser_done_evt, .sink_pins, .gpio_pins,
        .irq, .irq_valid, .irq_vector);
    vitt_core_model vitt_core_model_i (.aclk, .aresetn, .irq_valid, .irq_vector,
        .taken_vec);
    // ****************************************************************
    // clock, cycle count, helpers
    // ****************************************************************
    always #25 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic summarize;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic hang(input string nm);
        n_mismatch++;
        $display("[ERR] %s exp done got timeout", nm);
        summarize();
    endtask : hang
    // ****************************************************************
    // axi4-lite master: request held until its own ready edge
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int  j;
        logic aw, w;
        @(posedge aclk);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (j = 0; j < 100; j++) begin
            @(posedge aclk);
            if (aw && w && s_axi_bvalid) break;
            if (s_axi_awvalid && s_axi_awready) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wvalid && s_axi_wready) begin w = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        if (j == 100) hang("wr");
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int  j;
        logic ar;
        @(posedge aclk);
        ar = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (j = 0; j < 100; j++) begin
            @(posedge aclk);
            if (ar && s_axi_rvalid) break;
            if (s_axi_arvalid && s_axi_arready) begin ar = 1'b1; s_axi_arvalid <= 1'b0; end
        end
        if (j == 100) hang("rd");
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    // one-cycle event pulse on the input behind source v
    task automatic pulse(input int v);
        @(posedge aclk);
        if (v == 0) usb_bus_reset_evt <= 1'b1;
        else if (v == 10) ser_done_evt <= 1'b1;
        else ep_done_evt[v-3] <= 1'b1;
        @(posedge aclk);
        usb_bus_reset_evt <= 1'b0;
        ser_done_evt <= 1'b0;
        ep_done_evt <= 5'h00;
    endtask : pulse
    // drive pins, let the synchroniser settle, check sink/gpio status bits
    task automatic pin(input logic [3:0] sp, input logic [31:0] gp, input logic [1:0] ex);
        @(posedge aclk);
        sink_pins <= sp;
        gpio_pins <= gp;
        repeat (8) @(posedge aclk);
        rd(vitt_pkg::OFS_STAT);
        `CHK("pin_stat", ex, rdat[9:8])
        wr(vitt_pkg::OFS_STAT, 32'h0000_0300);
    endtask : pin
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(vitt_pkg::OFS_MASK); `CHK("mask_rst", vitt_pkg::RST_ZERO, rdat)
        wr(8'h40, 32'h5); `CHK("bad_wr", vitt_pkg::RESP_ERR, resp)
        rd(8'h40); `CHK("bad_rd", vitt_pkg::RESP_ERR, resp)
        for (k = 0; k < 4; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(vitt_pkg::OFS_MASK, {16'h0, lfsr_q});
            rd(vitt_pkg::OFS_MASK); `CHK("mask_rw", {21'h0, lfsr_q[10:0]}, rdat)
        end
        // every pulse source: own status bit, own vector, clearing; masking checked after the loop on source 4 only
        for (k = 0; k < 7; k++) begin
            s = srcs[k];
            wr(vitt_pkg::OFS_STAT, 32'h7ff);
            wr(vitt_pkg::OFS_MASK, 32'h1 << s);
            pulse(s);
            repeat (5) @(posedge aclk);
            `CHK("irq", 1'b1, irq)
            `CHK("core_vec", 4'(s), taken_vec)
            rd(vitt_pkg::OFS_VEC); `CHK("vec", 32'h10 | 32'(s), rdat)
            rd(vitt_pkg::OFS_STAT); `CHK("stat", 32'h1 << s, rdat & 32'h7f9)
            wr(vitt_pkg::OFS_STAT, 32'h1 << s); `CHK("irq_clr", 1'b0, irq)
        end
        wr(vitt_pkg::OFS_MASK, 32'h0);
        pulse(4);
        repeat (5) @(posedge aclk);
        `CHK("irq_masked", 1'b0, irq)
        // upper timer bits held from the low read, timer rate one per tick
        rd(vitt_pkg::OFS_TLO); c1 = cyc; t1 = rdat[7:0];
        rd(vitt_pkg::OFS_THI); t1 = t1 | (rdat[3:0] << 8);
        repeat (6000) @(posedge aclk);
        rd(vitt_pkg::OFS_THI); `CHK("thi_held", t1[11:8], rdat[3:0])
        rd(vitt_pkg::OFS_TLO); c2 = cyc; t2 = rdat[7:0];
        rd(vitt_pkg::OFS_THI); t2 = t2 | (rdat[3:0] << 8);
        d = (t2 - t1) & 32'hfff;
        e = (c2 - c1) / vitt_pkg::TICK_DIV;
        `CHK("tmr_rate", 1'b1, d >= e - 1 && d <= e + 1)
        // each tap fires just after its bit rises, never on the fall
        for (k = 0; k < 2; k++) begin
            wr(vitt_pkg::OFS_STAT, 32'h7ff);
            wr(vitt_pkg::OFS_MASK, 32'h1 << (k + 1));
            for (i = 0; i < 21000 && irq !== 1'b1; i++) @(posedge aclk);
            if (i == 21000) hang("tap");
            rd(vitt_pkg::OFS_TLO); t1 = rdat[7:0];
            rd(vitt_pkg::OFS_THI); t1 = t1 | (rdat[3:0] << 8);
            d = k ? (t1 & 32'h3ff) - 512 : (t1 & 32'h7f) - 64;
            `CHK("tap_pos", 1'b1, d == 0 || d == 1)
        end
        // pin masks and polarities
        wr(vitt_pkg::OFS_MASK, 32'h0);
        wr(vitt_pkg::OFS_STAT, 32'h7ff);
        wr(vitt_pkg::OFS_SMASK, 32'h1);
        wr(vitt_pkg::OFS_SPOL, 32'h0);
        wr(vitt_pkg::OFS_GMASK, 32'h0000_0100);
        wr(vitt_pkg::OFS_GPOL, 32'h2);
        pin(4'h1, 32'h0, 2'b01);
        pin(4'h3, 32'h0, 2'b00);
        pin(4'h2, 32'h0, 2'b00);
        pin(4'h2, 32'h0000_0100, 2'b00);
        pin(4'h2, 32'h0, 2'b10);
        pin(4'h2, 32'h1, 2'b00);
        wr(vitt_pkg::OFS_SPOL, 32'h1);
        pin(4'h3, 32'h1, 2'b00);
        pin(4'h2, 32'h1, 2'b01);
        summarize();
    end
    // hang guard
    initial begin
        repeat (90000) @(posedge aclk);
        hang("run");
    end
endmodule : vectored_irq_with_tick_timer_tb
